// ### hw/mmc_access.sv
// Memory-mapped access to the tag and data arrays of a 4-way cache.
// Assumes an APB master issuing longword transfers and a memory side
// that takes written-back lines and supplies fills as whole lines.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps

// Function
// - F0xxxxxx decodes to tag array.
// - F1xxxxxx decodes to data array.
// - Tag access: index 11:4, way 13:12.
// - Way code 00..11 selects ways 0..3.
// - Tag write takes tag, V, U, LRU.
// - Data access: index, way, longword 3:2.
// - Longword code selects word in line.
// - Data array access leaves tags untouched.
// - Data read returns selected longword.
// - Data write stores selected longword.
// - Associative write updates matching V, U.
// - Clearing V of dirty line writes back.
// - Hit needs tag match and valid.
// - Fill and write-back whole 16-byte lines.
module mmc_access
  import mmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] lookup_addr,
  output logic lookup_hit,
  output logic [1:0] lookup_way,
  input wire logic fill_valid,
  output logic fill_ready,
  input wire line_s fill_line,
  input wire logic [1:0] fill_way,
  output logic wb_valid,
  input wire logic wb_ready,
  output line_s wb_line
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [TAG_W-1:0] tag_mem [WAYS][SETS];
  logic [31:0] data_mem [WAYS][SETS][LWS];
  logic [5:0] lru_mem [SETS];
  logic [SETS-1:0] valid_ff [WAYS];
  logic [SETS-1:0] dirty_ff [WAYS];

  apb_st_e st_ff;
  apb_st_e nxt_st;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic err_ff;
  logic nxt_err;
  logic hit_ff;
  logic nxt_hit;
  logic [1:0] hway_ff;
  logic [1:0] nxt_hway;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  logic [7:0] region;
  logic is_tag;
  logic is_data;
  logic [IDX_W-1:0] idx;
  logic [1:0] way;
  logic [1:0] lw;
  logic assoc;
  logic bad;
  tag_word_s wd;

  assign region = paddr[REGION_LSB +: 8];
  assign is_tag = (region == TAG_REGION);
  assign is_data = (region == DATA_REGION);
  assign idx = paddr[IDX_LSB +: IDX_W];
  assign way = paddr[WAY_LSB +: 2];
  assign lw = paddr[LW_LSB +: 2];
  assign assoc = paddr[ASSOC_BIT];
  // Unmapped or misaligned transfers are answered with an error; a
  // misaligned one is software's fault but is refused rather than
  // silently rounded down.
  assign bad = !(is_tag || is_data) || (paddr[1:0] != 2'b00);
  assign wd = tag_word_s'(pwdata);

  // ------------------------------------------------------------------
  // Tag array write and write-back decision
  // ------------------------------------------------------------------
  logic [WAYS-1:0] match;
  logic any_match;
  logic [1:0] mway;
  logic [1:0] tway;
  logic commit;
  logic tag_we;
  logic data_we;
  logic old_v;
  logic old_u;
  logic new_v;
  logic apb_wb;
  logic fill_go;
  logic fill_wb;
  logic [IDX_W-1:0] fidx;
  logic [IDX_W-1:0] lidx;
  logic wb_in_valid;
  logic wb_in_ready;
  line_s wb_in_line;
  line_s wb_out_line;

  // Associative compare of the write tag against all ways of the set.
  always_comb begin
    any_match = 1'b0;
    mway = 2'b00;
    for (int w = 0; w < WAYS; w++) begin
      match[w] = (tag_mem[w][idx] == wd.tag);
      if (match[w] && !any_match) begin
        any_match = 1'b1;
        mway = 2'(w);
      end
    end
  end

  // A write only lands in the cycle that the bus answers ready.
  assign commit = (st_ff == ST_DONE) && psel && penable && pwrite && !bad;
  assign tway = assoc ? mway : way;
  assign tag_we = commit && is_tag && (!assoc || any_match);
  assign data_we = commit && is_data;
  assign old_v = valid_ff[tway][idx];
  assign old_u = dirty_ff[tway][idx];
  assign new_v = wd.valid;
  assign apb_wb = is_tag && (!assoc || any_match) && old_v && old_u && !new_v;

  // Fills wait for an idle bus and a free buffer, so a dirty victim
  // always has somewhere to go before its line is overwritten.
  assign fidx = fill_line.addr[IDX_LSB +: IDX_W];
  assign fill_ready = (st_ff == ST_IDLE) && !psel && wb_in_ready;
  assign fill_go = fill_valid && fill_ready;
  assign fill_wb = valid_ff[fill_way][fidx] && dirty_ff[fill_way][fidx];

  always_comb begin
    wb_in_valid = 1'b0;
    wb_in_line = '0;
    if (commit && pwrite && apb_wb) begin
      wb_in_valid = 1'b1;
      wb_in_line.addr = {tag_mem[tway][idx][TAG_W-1:2], idx, LINE_OFS};
      for (int k = 0; k < LWS; k++) begin
        wb_in_line.data[k] = data_mem[tway][idx][k];
      end
    end else if (fill_go && fill_wb) begin
      wb_in_valid = 1'b1;
      wb_in_line.addr = {tag_mem[fill_way][fidx][TAG_W-1:2], fidx, LINE_OFS};
      for (int k = 0; k < LWS; k++) begin
        wb_in_line.data[k] = data_mem[fill_way][fidx][k];
      end
    end
  end

  line_buffer #(
    .WIDTH($bits(line_s))
  ) i_line_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(wb_in_valid),
    .in_ready(wb_in_ready),
    .in_data(wb_in_line),
    .out_valid(wb_valid),
    .out_ready(wb_ready),
    .out_data(wb_out_line)
  );
  assign wb_line = wb_out_line;

  // ------------------------------------------------------------------
  // Array storage, one copy of the logic per way
  // ------------------------------------------------------------------
  genvar gw;
  generate
    for (gw = 0; gw < WAYS; gw++) begin : g_way
      logic wsel;
      logic fsel;
      assign wsel = tag_we && (tway == 2'(gw));
      assign fsel = fill_go && (fill_way == 2'(gw));

      // Tag and data contents carry no reset; valid bits guard them.
      always_ff @(posedge pclk) begin
        if (wsel && !assoc) begin
          tag_mem[gw][idx] <= wd.tag;
        end
        if (data_we && (way == 2'(gw))) begin
          data_mem[gw][idx][lw] <= pwdata;
        end
        if (fsel) begin
          tag_mem[gw][fidx] <= fill_line.addr[TAG_LSB +: TAG_W];
          for (int k = 0; k < LWS; k++) begin
            data_mem[gw][fidx][k] <= fill_line.data[k];
          end
        end
      end

      // Flags reset to invalid and clean.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          valid_ff[gw] <= '0;
          dirty_ff[gw] <= '0;
        end else if (wsel) begin
          valid_ff[gw][idx] <= wd.valid;
          dirty_ff[gw][idx] <= wd.dirty;
        end else if (fsel) begin
          valid_ff[gw][fidx] <= 1'b1;
          dirty_ff[gw][fidx] <= 1'b0;
        end
      end
    end
  endgenerate

  // Replacement-order bits are kept per set, as the policy needs.
  always_ff @(posedge pclk) begin
    if (tag_we && !assoc) begin
      lru_mem[idx] <= wd.lru;
    end
  end

  // ------------------------------------------------------------------
  // APB answer and lookup
  // ------------------------------------------------------------------
  assign lidx = lookup_addr[IDX_LSB +: IDX_W];

  // The access phase waits one cycle so that read data leaves a flop;
  // a write needing the busy write-back buffer waits longer.
  always_comb begin
    nxt_st = st_ff;
    nxt_prdata = prdata_ff;
    nxt_err = err_ff;
    nxt_hit = 1'b0;
    nxt_hway = 2'b00;
    case (st_ff)
      ST_IDLE: begin
        if (psel && penable &&
            (!pwrite || bad || !apb_wb || wb_in_ready)) begin
          nxt_st = ST_DONE;
          nxt_err = bad;
          nxt_prdata = PRDATA_RST;
          if (!pwrite && !bad && is_tag) begin
            nxt_prdata = {tag_mem[way][idx], lru_mem[idx], 2'b00,
                          dirty_ff[way][idx], valid_ff[way][idx]};
          end else if (!pwrite && !bad) begin
            nxt_prdata = data_mem[way][idx][lw];
          end
        end
      end
      ST_DONE: begin
        nxt_st = ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    for (int w = 0; w < WAYS; w++) begin
      if (valid_ff[w][lidx] && !nxt_hit &&
          (tag_mem[w][lidx] == lookup_addr[TAG_LSB +: TAG_W])) begin
        nxt_hit = 1'b1;
        nxt_hway = 2'(w);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      prdata_ff <= PRDATA_RST;
      err_ff <= 1'b0;
      hit_ff <= 1'b0;
      hway_ff <= 2'b00;
    end else begin
      st_ff <= nxt_st;
      prdata_ff <= nxt_prdata;
      err_ff <= nxt_err;
      hit_ff <= nxt_hit;
      hway_ff <= nxt_hway;
    end
  end

  assign pready = (st_ff == ST_DONE);
  assign pslverr = (st_ff == ST_DONE) && err_ff;
  assign prdata = prdata_ff;
  assign lookup_hit = hit_ff;
  assign lookup_way = hway_ff;

endmodule

// ### hw/mmc_pkg.sv
// Constants and carrier types for the memory-mapped cache access block.
// Assumes a 32-bit APB master and a 4-way cache with 16-byte lines.
package mmc_pkg;

  // ------------------------------------------------------------------
  // Address map and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] TAG_REGION = 8'hf0;
  localparam logic [7:0] DATA_REGION = 8'hf1;
  localparam int REGION_LSB = 24;
  localparam int IDX_LSB = 4;
  localparam int WAY_LSB = 12;
  localparam int LW_LSB = 2;
  localparam int ASSOC_BIT = 3;
  localparam int TAG_LSB = 10;
  localparam int IDX_W = 8;
  localparam int SETS = 256;
  localparam int WAYS = 4;
  localparam int LWS = 4;
  localparam int TAG_W = 22;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
  localparam logic [3:0] LINE_OFS = 4'h0;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  // Tag array word, used for writes and reads alike.
  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [5:0] lru;
    logic [1:0] rsv;
    logic dirty;
    logic valid;
  } tag_word_s;

  // One whole cache line with its physical byte address.
  typedef struct packed {
    logic [31:0] addr;
    logic [LWS-1:0][31:0] data;
  } line_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } apb_st_e;

endpackage

// ### hw/line_buffer.sv
// One-entry line buffer between the cache and the external write path.
// Assumes the drain side follows valid/ready and may stall indefinitely.
`timescale 1ns/10ps
module line_buffer #(
  parameter int WIDTH = 160
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic full_ff;
  logic nxt_full;
  logic [WIDTH-1:0] data_ff;
  logic [WIDTH-1:0] nxt_data;

  // Accept only when empty, so a full buffer stalls the cache side.
  assign in_ready = ~full_ff;
  assign out_valid = full_ff;
  assign out_data = data_ff;

  // Occupancy and payload next values.
  always_comb begin
    nxt_full = full_ff;
    nxt_data = data_ff;
    if (full_ff && out_ready) begin
      nxt_full = 1'b0;
    end
    if (in_valid && !full_ff) begin
      nxt_full = 1'b1;
      nxt_data = in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      full_ff <= nxt_full;
      data_ff <= nxt_data;
    end
  end

endmodule

// ### bench/mmc_access_sva.sv
// Checker for the cache access block, seeing its ports only.
// Assumes the bind at the foot of this file and one pclk domain.
`timescale 1ns/10ps
module mmc_access_sva
  import mmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic lookup_hit,
  input wire logic [1:0] lookup_way,
  input wire logic fill_ready,
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire line_s wb_line
);
  // One domain, so one clocking and one reset serve every property.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  wait_state_a: assert property ($rose(penable) |-> !pready)
    else $error("access phase without wait state");
  ready_bound_a: assert property (psel && penable |-> ##[0:100] pready)
    else $error("transfer never answered");
  unmapped_err_a: assert property (
      pready && paddr[31:25] != 7'h78 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (
      pready && paddr[31:25] == 7'h78 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped longword access refused");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  wb_hold_a: assert property (
      wb_valid && !wb_ready |=> wb_valid && $stable(wb_line))
    else $error("write-back line dropped or changed");
  wb_align_a: assert property (
      wb_valid |-> wb_line.addr[3:0] == LINE_OFS)
    else $error("write-back not line aligned");
  miss_way_a: assert property (!lookup_hit |-> lookup_way == 2'b00)
    else $error("miss reports a way");
  fill_block_a: assert property (psel |-> !fill_ready)
    else $error("fill accepted during APB access");
endmodule

bind mmc_access mmc_access_sva i_mmc_access_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lookup_hit(lookup_hit), .lookup_way(lookup_way),
  .fill_ready(fill_ready), .wb_valid(wb_valid), .wb_ready(wb_ready),
  .wb_line(wb_line)
);

// ### bench/mem_side_model.sv
// Memory side: drains written-back lines and supplies line fills.
// Assumes one pclk domain; the bench calls give_fill and reads got.
`timescale 1ns/10ps
module mem_side_model
  import mmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wb_valid,
  input wire line_s wb_line,
  output logic wb_ready,
  input wire logic fill_ready,
  output logic fill_valid,
  output line_s fill_line,
  output logic [1:0] fill_way
);
  line_s got[$];

  initial begin
    wb_ready = 1'b0;
    fill_valid = 1'b0;
    fill_way = 2'b00;
    fill_line = '0;
  end

  // Random stalls make the block hold its line for several cycles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_ready <= 1'b0;
    end else begin
      if (wb_valid && wb_ready) begin
        got.push_back(wb_line);
      end
      wb_ready <= ($urandom_range(0, 3) == 0);
    end
  end

  task automatic give_fill(input line_s l, input logic [1:0] w);
    fill_line <= l;
    fill_way <= w;
    fill_valid <= 1'b1;
    do begin
      @(posedge pclk);
    end while (fill_ready !== 1'b1);
    fill_valid <= 1'b0;
    fill_line <= ~l;
    fill_way <= ~w;
  endtask
endmodule

// ### bench/memory_mapped_cache_access_test.sv
// Self-checking bench for the cache access block and its memory side.
// Assumes one pclk domain; APB answers are paired with queued notes.
`timescale 1ns/10ps
module memory_mapped_cache_access_test;
  import mmc_pkg::*;
  typedef struct packed {
    logic err;
    logic [31:0] d;
    logic [31:0] m;
  } note_s;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, lookup_hit, wb_valid, wb_ready;
  logic fill_valid, fill_ready;
  logic [31:0] paddr = '0, pwdata = '0, lookup_addr = '0, prdata;
  logic [1:0] lookup_way, fill_way;
  line_s fill_line, wb_line, fl;
  note_s notes[$];
  note_s n;
  int fails = 0, comparisons = 0, cycles = 0;
  logic [7:0] s;
  logic [21:0] tg[4];
  logic [31:0] dat[4][4];

  always #20 pclk = ~pclk;

  mmc_access i_mmc_access (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lookup_addr(lookup_addr), .lookup_hit(lookup_hit),
    .lookup_way(lookup_way), .fill_valid(fill_valid),
    .fill_ready(fill_ready), .fill_line(fill_line), .fill_way(fill_way),
    .wb_valid(wb_valid), .wb_ready(wb_ready), .wb_line(wb_line));
  mem_side_model i_mem_side_model (.pclk(pclk), .presetn(presetn),
    .wb_valid(wb_valid), .wb_line(wb_line), .wb_ready(wb_ready),
    .fill_ready(fill_ready), .fill_valid(fill_valid),
    .fill_line(fill_line), .fill_way(fill_way));

  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [31:0] da(int w, int l);
    return {8'hf1, 10'h0, w[1:0], s, l[1:0], 2'b00};
  endfunction
  function automatic logic [31:0] ta(int w, logic a);
    return {8'hf0, 10'h0, w[1:0], s, a, 3'b000};
  endfunction
  function automatic logic [31:0] tw(logic [21:0] t, logic u, logic v);
    return {t, 6'h15, 2'b00, u, v};
  endfunction

  // A write notes zero read data; a read notes its masked expectation.
  // longword transfers only
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d, input logic e, input logic [31:0] m);
    notes.push_back({e, w ? 32'h0 : d, m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0, 32'hffffffff);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] d,
      input logic [31:0] m = 32'hffffffff);
    xfer(1'b0, a, d, 1'b0, m);
  endtask
  task automatic look(input logic [31:0] a, input logic h,
      input logic [1:0] w);
    lookup_addr <= a;
    repeat (2) @(posedge pclk);
    check({lookup_hit, lookup_way} === {h, w}, "lookup result");
  endtask

  // Each finished transfer is compared with the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      n = notes.pop_front();
      check({pslverr, prdata & n.m} === {n.err, n.d & n.m}, "apb answer");
    end
  end

  // Cuts a hang short; the full run needs well under a thousand cycles.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h0d5d));
    s = 8'($urandom);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int w = 0; w < 4; w++) begin
      tg[w] = {20'($urandom), s[7:6]};
      wr(ta(w, 1'b0), tw(tg[w], 1'b1, 1'b1));
      rd(ta(w, 1'b0), tw(tg[w], 1'b1, 1'b1));
      for (int l = 0; l < 4; l++) begin
        dat[w][l] = $urandom;
        wr(da(w, l), dat[w][l]);
      end
    end
    for (int w = 0; w < 4; w++) begin
      for (int l = 0; l < 4; l++) begin
        rd(da(w, l), dat[w][l]);
      end
      rd(ta(w, 1'b0), tw(tg[w], 1'b1, 1'b1));
      look({tg[w], s[5:0], 4'h0}, 1'b1, 2'(w));
    end
    look({tg[0] ^ 22'h4, s[5:0], 4'h0}, 1'b0, 2'b00);
    wr(ta(0, 1'b1), tw(tg[0] ^ 22'h4, 1'b0, 1'b0));
    rd(ta(0, 1'b0), tw(tg[0], 1'b1, 1'b1));
    wr(ta(0, 1'b1), tw(tg[2], 1'b0, 1'b0));
    repeat (60) if (i_mem_side_model.got.size() == 0) @(posedge pclk);
    check(i_mem_side_model.got.size() == 1, "write-back count");
    fl = i_mem_side_model.got.pop_front();
    check(fl === {tg[2], s[5:0], 4'h0, dat[2][3], dat[2][2], dat[2][1],
      dat[2][0]}, "write-back line");
    rd(ta(2, 1'b0), tw(tg[2], 1'b0, 1'b0));
    look({tg[2], s[5:0], 4'h0}, 1'b0, 2'b00);
    fl.addr = {tg[1] ^ 22'h8, s[5:0], 4'h0};
    fl.data = {$urandom, $urandom, $urandom, $urandom};
    i_mem_side_model.give_fill(fl, 2'd2);
    for (int l = 0; l < 4; l++) begin
      rd(da(2, l), fl.data[l]);
    end
    rd(ta(2, 1'b0), {fl.addr[31:10], 10'h1}, 32'hfffffc03);
    // A fill over a valid dirty victim must push the old line out first.
    fl.addr = {tg[0] ^ 22'h10, s[5:0], 4'h0};
    i_mem_side_model.give_fill(fl, 2'd3);
    repeat (60) if (i_mem_side_model.got.size() == 0) @(posedge pclk);
    fl = i_mem_side_model.got.pop_front();
    check(fl === {tg[3], s[5:0], 4'h0, dat[3][3], dat[3][2], dat[3][1],
      dat[3][0]}, "victim write-back");
    // A second reset in mid-run must clear the valid and dirty flags of way 0 in set s.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    look({tg[0], s[5:0], 4'h0}, 1'b0, 2'b00);
    rd(ta(0, 1'b0), 32'h0, 32'h00000003);
    xfer(1'b0, 32'hf200_0000, 32'h0, 1'b1, 32'hffffffff);
    xfer(1'b0, da(1, 1) | 32'h2, 32'h0, 1'b1, 32'hffffffff);
    xfer(1'b1, 32'h0000_0040, 32'hffffffff, 1'b1, 32'hffffffff);
    repeat (2) @(posedge pclk);
    give_verdict();
  end
endmodule
